//--- rtl/led_matrix_pkg.sv
package led_matrix_pkg;

    // Pixel chain geometry.
    localparam int PIXEL_BITS       = 160;
    localparam int CHAIN_CHIPS      = 2;
    localparam int CHAIN_BITS       = PIXEL_BITS * CHAIN_CHIPS;
    localparam int LEN_WIDTH        = 9;

    // Control word layout.
    localparam int CTRL_BITS        = 7;
    localparam int CTRL_SHIFT_BITS  = 8;
    localparam int CTRL_WORD_POS    = 7;
    localparam int SLEEP_OFF_POS    = 6;
    localparam int PEAK_WIDTH       = 6;
    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 7'h00;

    // Refresh scan.
    localparam int SCAN_PHASES      = 8;
    localparam int PHASE_WIDTH      = 3;
    localparam int SCAN_WIDTH       = CHAIN_BITS / SCAN_PHASES;

    // Pin synchroniser vector layout.
    localparam int SYNC_WIDTH       = 8;
    localparam int POS_SER_CLK      = 7;
    localparam int POS_SER_DATA     = 6;
    localparam int POS_WINDOW_N     = 5;
    localparam int POS_TARGET       = 4;
    localparam int POS_DISPLAY_OFF  = 3;
    localparam int POS_OSC_SEL      = 2;
    localparam int POS_OSC_LINE     = 1;
    localparam int POS_RESET_N      = 0;
    localparam logic [SYNC_WIDTH-1:0] SYNC_IDLE = 8'h2C;

    // Timing.
    localparam int CLK_PERIOD_NS    = 10;
    localparam int CLK_FREQ_KHZ     = 100000;
    localparam int INT_OSC_KHZ      = 160;
    localparam int INT_OSC_HALF_CYC = CLK_FREQ_KHZ / (2 * INT_OSC_KHZ);
    localparam int OSC_CNT_WIDTH    = 9;
    localparam int SER_HALF_NS      = 130;
    localparam int SER_HALF_CYC     = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WINDOW_SETUP_NS  = 60;
    localparam int WINDOW_SETUP_CYC = (WINDOW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_WIDTH      = 5;

    typedef enum logic [2:0] {
        H_IDLE    = 3'h0,
        H_SELECT  = 3'h1,
        H_LOW     = 3'h2,
        H_HIGH    = 3'h3,
        H_END     = 3'h4,
        H_RELEASE = 3'h5
    } host_state_t;

endpackage

//--- rtl/led_matrix_if.sv
`timescale 1ns/1ps
interface led_matrix_if;
    logic serClk;
    logic serData;
    logic writeWindowN;
    logic targetRegisterChoice;
    logic displayOffInput;
    logic oscSel;
    logic oscExt;
    logic deviceResetN;
    logic dataOut;
    logic oscOut;
    logic oscOutEn;
    logic oscLine;

    // The display timebase pin level resolved from the device's enable.
    assign oscLine = oscOutEn ? oscOut : oscExt;

    modport device (
        input  serClk,
        input  serData,
        input  writeWindowN,
        input  targetRegisterChoice,
        input  displayOffInput,
        input  oscSel,
        input  oscLine,
        input  deviceResetN,
        output dataOut,
        output oscOut,
        output oscOutEn
    );

    modport host (
        output serClk,
        output serData,
        output writeWindowN,
        output targetRegisterChoice,
        output displayOffInput,
        output oscSel,
        output oscExt,
        output deviceResetN,
        input  dataOut,
        input  oscLine
    );
endinterface

//--- rtl/led_matrix_device.sv
`timescale 1ns/1ps
module led_matrix_device
    import led_matrix_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    led_matrix_if.device               link,
    output logic [SCAN_WIDTH-1:0]      ledGroup,
    output logic [PHASE_WIDTH-1:0]     scanPhase,
    output logic [PEAK_WIDTH-1:0]      peakCurrent,
    output logic                       referenceOn,
    output logic                       sleepState
);

    logic [SYNC_WIDTH-1:0]      syncA;
    logic [SYNC_WIDTH-1:0]      syncB;
    logic [SYNC_WIDTH-1:0]      prevB;
    logic                       sClk;
    logic                       pClk;
    logic                       sData;
    logic                       sWinN;
    logic                       pWinN;
    logic                       sTarget;
    logic                       sBlank;
    logic                       sOscSel;
    logic                       sOscLine;
    logic                       pOscLine;
    logic                       sResetN;
    logic                       serRise;
    logic                       winFall;
    logic                       winRise;
    logic                       shiftEn;
    logic                       latchEn;
    logic                       targetLatched;
    logic                       activeTarget;
    logic [CHAIN_BITS-1:0]      pixelShift;
    logic [CHAIN_BITS-1:0]      pixelLatched;
    logic [CTRL_SHIFT_BITS-1:0] ctrlShift;
    logic [CTRL_BITS-1:0]       ctrlWord0;
    logic [CTRL_BITS-1:0]       ctrlWord1;
    logic                       asleep;
    logic [OSC_CNT_WIDTH-1:0]   oscCnt;
    logic                       intOsc;
    logic                       intTick;
    logic                       extTick;
    logic                       refreshTick;
    logic                       dataOutReg;
    logic                       oscOutReg;
    logic                       oscOutEnReg;

    // Two-stage synchroniser for every pin from the host side.
    // It resets to the idle pin levels so no false window edge follows reset.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA <= SYNC_IDLE;
            syncB <= SYNC_IDLE;
            prevB <= SYNC_IDLE;
        end else begin
            syncA <= {link.serClk, link.serData, link.writeWindowN,
                      link.targetRegisterChoice, link.displayOffInput,
                      link.oscSel, link.oscLine, link.deviceResetN};
            syncB <= syncA;
            prevB <= syncB;
        end
    end

    assign sClk     = syncB[POS_SER_CLK];
    assign pClk     = prevB[POS_SER_CLK];
    assign sData    = syncB[POS_SER_DATA];
    assign sWinN    = syncB[POS_WINDOW_N];
    assign pWinN    = prevB[POS_WINDOW_N];
    assign sTarget  = syncB[POS_TARGET];
    assign sBlank   = syncB[POS_DISPLAY_OFF];
    assign sOscSel  = syncB[POS_OSC_SEL];
    assign sOscLine = syncB[POS_OSC_LINE];
    assign pOscLine = prevB[POS_OSC_LINE];
    assign sResetN  = syncB[POS_RESET_N];

    assign serRise = sClk & ~pClk;
    assign winFall = pWinN & ~sWinN;
    assign winRise = ~pWinN & sWinN;
    assign shiftEn = serRise & ~sWinN;
    assign latchEn = winRise & ~sClk;

    // A clock rise seen together with the window fall already uses the new choice.
    assign activeTarget = winFall ? sTarget : targetLatched;

    // Target register choice held for the whole write.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            targetLatched <= 1'b0;
        end else if (winFall) begin
            targetLatched <= sTarget;
        end
    end

    // Pixel chain: chip 0 fills the low half, its top bit feeds chip 1.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pixelShift <= '0;
        end else if (shiftEn && !activeTarget) begin
            pixelShift <= {pixelShift[CHAIN_BITS-2:0], sData};
        end
    end

    // Latched pixel pattern; the reset pin has no effect here.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pixelLatched <= '0;
        end else if (latchEn && !targetLatched) begin
            pixelLatched <= pixelShift;
        end
    end

    // Control shift register.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlShift <= '0;
        end else if (!sResetN) begin
            ctrlShift <= '0;
        end else if (shiftEn && activeTarget) begin
            ctrlShift <= {ctrlShift[CTRL_SHIFT_BITS-2:0], sData};
        end
    end

    // Control words; the top shifted bit picks word one or word zero.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlWord0 <= CTRL_RESET;
            ctrlWord1 <= CTRL_RESET;
        end else if (!sResetN) begin
            ctrlWord0 <= CTRL_RESET;
            ctrlWord1 <= CTRL_RESET;
        end else if (latchEn && targetLatched) begin
            if (ctrlShift[CTRL_WORD_POS]) begin
                ctrlWord1 <= ctrlShift[CTRL_BITS-1:0];
            end else begin
                ctrlWord0 <= ctrlShift[CTRL_BITS-1:0];
            end
        end
    end

    assign asleep = ~ctrlWord0[SLEEP_OFF_POS];

    // Serial output carries the bit pushed off the end of the selected chain.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dataOutReg <= 1'b0;
        end else if (shiftEn) begin
            if (activeTarget) begin
                dataOutReg <= ctrlShift[CTRL_SHIFT_BITS-1];
            end else begin
                dataOutReg <= pixelShift[CHAIN_BITS-1];
            end
        end
    end

    // Internal display oscillator, stopped in sleep or when not chosen.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oscCnt <= '0;
            intOsc <= 1'b0;
        end else if (asleep || !sOscSel) begin
            oscCnt <= '0;
            intOsc <= 1'b0;
        end else if (oscCnt == OSC_CNT_WIDTH'(INT_OSC_HALF_CYC - 1)) begin
            oscCnt <= '0;
            intOsc <= ~intOsc;
        end else begin
            oscCnt <= oscCnt + 1'b1;
        end
    end

    assign intTick = sOscSel && !intOsc && !asleep &&
                     (oscCnt == OSC_CNT_WIDTH'(INT_OSC_HALF_CYC - 1));
    assign extTick = !sOscSel && sOscLine && !pOscLine;
    assign refreshTick = sOscSel ? intTick : extTick;

    // Timebase pin: driven with the internal oscillator, else an input.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oscOutReg   <= 1'b0;
            oscOutEnReg <= 1'b0;
        end else begin
            oscOutReg   <= intOsc;
            oscOutEnReg <= sOscSel;
        end
    end

    // Refresh scan of the latched pattern.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scanPhase <= '0;
        end else if (refreshTick) begin
            scanPhase <= scanPhase + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ledGroup <= '0;
        end else if (sBlank || asleep) begin
            ledGroup <= '0;
        end else begin
            ledGroup <= pixelLatched[scanPhase*SCAN_WIDTH +: SCAN_WIDTH];
        end
    end

    // Drive strength and reference current follow control word zero.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            peakCurrent <= '0;
            referenceOn <= 1'b0;
            sleepState  <= 1'b1;
        end else begin
            peakCurrent <= asleep ? '0 : ctrlWord0[PEAK_WIDTH-1:0];
            referenceOn <= ~asleep;
            sleepState  <= asleep;
        end
    end

    assign link.dataOut  = dataOutReg;
    assign link.oscOut   = oscOutReg;
    assign link.oscOutEn = oscOutEnReg;

endmodule // led_matrix_device

//--- rtl/led_matrix_host.sv
`timescale 1ns/1ps
module led_matrix_host
    import led_matrix_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    led_matrix_if.host                 link,
    input  wire logic                  sendStart,
    input  wire logic                  sendTarget,
    input  wire logic [LEN_WIDTH-1:0]  sendLen,
    input  wire logic [CHAIN_BITS-1:0] sendData,
    input  wire logic                  displayOff,
    input  wire logic                  oscSelect,
    input  wire logic                  extOsc,
    input  wire logic                  resetDisplay,
    output logic                       busy,
    output logic                       done
);

    host_state_t                state;
    logic [TIMER_WIDTH-1:0]     timer;
    logic [LEN_WIDTH-1:0]       bitsLeft;
    logic [CHAIN_BITS-1:0]      shiftData;
    logic                       serClkReg;
    logic                       serDataReg;
    logic                       windowNReg;
    logic                       targetReg;
    logic                       blankReg;
    logic                       oscSelReg;
    logic                       oscExtReg;
    logic                       resetNReg;

    localparam logic [TIMER_WIDTH-1:0] HALF_LOAD  = TIMER_WIDTH'(SER_HALF_CYC - 1);
    localparam logic [TIMER_WIDTH-1:0] SETUP_LOAD = TIMER_WIDTH'(WINDOW_SETUP_CYC - 1);

    // Static pins registered from the user side.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            blankReg  <= 1'b1;
            oscSelReg <= 1'b1;
            oscExtReg <= 1'b0;
            resetNReg <= 1'b0;
        end else begin
            blankReg  <= displayOff;
            oscSelReg <= oscSelect;
            oscExtReg <= extOsc;
            resetNReg <= ~resetDisplay;
        end
    end

    // Write sequence: choice, window low, bits, clock low, window high.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state      <= H_IDLE;
            timer      <= '0;
            bitsLeft   <= '0;
            shiftData  <= '0;
            serClkReg  <= 1'b0;
            serDataReg <= 1'b0;
            windowNReg <= 1'b1;
            targetReg  <= 1'b0;
            busy       <= 1'b0;
            done       <= 1'b0;
        end else begin
            done <= 1'b0;
            if (timer != '0) begin
                timer <= timer - 1'b1;
            end else begin
                case (state)
                    H_IDLE: begin
                        if (sendStart) begin
                            shiftData <= sendData;
                            bitsLeft  <= sendLen;
                            targetReg <= sendTarget;
                            busy      <= 1'b1;
                            timer     <= SETUP_LOAD;
                            state     <= H_SELECT;
                        end
                    end
                    H_SELECT: begin
                        windowNReg <= 1'b0;
                        serDataReg <= shiftData[CHAIN_BITS-1];
                        shiftData  <= {shiftData[CHAIN_BITS-2:0], 1'b0};
                        timer      <= HALF_LOAD;
                        state      <= (bitsLeft == '0) ? H_END : H_LOW;
                    end
                    H_LOW: begin
                        serClkReg <= 1'b1;
                        bitsLeft  <= bitsLeft - 1'b1;
                        timer     <= HALF_LOAD;
                        state     <= H_HIGH;
                    end
                    H_HIGH: begin
                        serClkReg <= 1'b0;
                        timer     <= HALF_LOAD;
                        if (bitsLeft == '0) begin
                            state <= H_END;
                        end else begin
                            serDataReg <= shiftData[CHAIN_BITS-1];
                            shiftData  <= {shiftData[CHAIN_BITS-2:0], 1'b0};
                            state      <= H_LOW;
                        end
                    end
                    H_END: begin
                        windowNReg <= 1'b1;
                        timer      <= HALF_LOAD;
                        state      <= H_RELEASE;
                    end
                    H_RELEASE: begin
                        busy  <= 1'b0;
                        done  <= 1'b1;
                        state <= H_IDLE;
                    end
                    default: begin
                        state <= H_IDLE;
                    end
                endcase
            end
        end
    end

    assign link.serClk               = serClkReg;
    assign link.serData              = serDataReg;
    assign link.writeWindowN         = windowNReg;
    assign link.targetRegisterChoice = targetReg;
    assign link.displayOffInput      = blankReg;
    assign link.oscSel               = oscSelReg;
    assign link.oscExt               = oscExtReg;
    assign link.deviceResetN         = resetNReg;

endmodule // led_matrix_host

//--- testbench/led_matrix_sva.sv
`timescale 1ns/1ps
module led_matrix_sva
    import led_matrix_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic                   serClk,
    input wire logic                   serData,
    input wire logic                   writeWindowN,
    input wire logic                   targetRegisterChoice,
    input wire logic                   displayOffInput,
    input wire logic                   oscSel,
    input wire logic                   oscExt,
    input wire logic                   deviceResetN,
    input wire logic                   dataOut,
    input wire logic                   oscOut,
    input wire logic                   oscOutEn,
    input wire logic                   oscLine,
    input wire logic [SCAN_WIDTH-1:0]  ledGroup,
    input wire logic [PHASE_WIDTH-1:0] scanPhase,
    input wire logic [PEAK_WIDTH-1:0]  peakCurrent,
    input wire logic                   referenceOn,
    input wire logic                   sleepState
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence pin_reset_s;
        !deviceResetN [*3];
    endsequence

    sequence high_phase_s;
        ##12 serClk ##1 !serClk;
    endsequence

    reset_clears_a: assert property (pin_reset_s |-> ##[1:4] sleepState)
        else $error("pin reset did not enter sleep");
    sleep_dark_a: assert property (sleepState [*2] |-> ledGroup == '0)
        else $error("leds lit while asleep");
    sleep_ref_a: assert property (sleepState [*2] |-> !referenceOn && peakCurrent == '0)
        else $error("reference on while asleep");
    awake_ref_a: assert property (!sleepState [*2] |-> referenceOn)
        else $error("reference off while awake");
    blank_dark_a: assert property (displayOffInput [*6] |-> ledGroup == '0)
        else $error("leds lit while blanked");
    phase_step_a: assert property ($changed(scanPhase) |->
        scanPhase == $past(scanPhase) + 3'h1)
        else $error("scan phase skipped");
    osc_stop_a: assert property ((oscOutEn && sleepState) [*3] |=> $stable(scanPhase))
        else $error("internal timebase ran in sleep");
    osc_int_a: assert property (oscSel [*5] |-> oscOutEn)
        else $error("timebase pin not driven");
    osc_ext_a: assert property (!oscSel [*5] |-> !oscOutEn)
        else $error("timebase pin driven on external");
    window_end_a: assert property ($rose(writeWindowN) |-> !serClk)
        else $error("window closed with clock high");
    clock_window_a: assert property ($rose(serClk) |-> !writeWindowN)
        else $error("clock outside window");
    choice_hold_a: assert property ($fell(writeWindowN) |->
        $stable(targetRegisterChoice) ##1 $stable(targetRegisterChoice))
        else $error("choice moved at window fall");
    high_time_a: assert property ($rose(serClk) |-> high_phase_s)
        else $error("clock high phase wrong");
    quiet_out_a: assert property ((writeWindowN && deviceResetN) [*8] |-> $stable(dataOut))
        else $error("data out moved outside window");
endmodule // led_matrix_sva

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import led_matrix_pkg::*;
    typedef struct {logic [2:0] sel; logic [39:0] val;} note_t;
    logic                   clk = 1'b0;
    logic                   reset_n = 1'b0;
    logic                   sendStart = 1'b0;
    logic                   sendTarget = 1'b0;
    logic [LEN_WIDTH-1:0]   sendLen = '0;
    logic [CHAIN_BITS-1:0]  sendData = '0;
    logic                   displayOff = 1'b0;
    logic                   oscSelect = 1'b1;
    logic                   extOsc = 1'b0;
    logic                   resetDisplay = 1'b0;
    logic                   busy;
    logic                   done;
    logic                   referenceOn;
    logic                   sleepState;
    logic [SCAN_WIDTH-1:0]  ledGroup;
    logic [PHASE_WIDTH-1:0] scanPhase;
    logic [PHASE_WIDTH-1:0] phase;
    logic [PEAK_WIDTH-1:0]  peakCurrent;
    logic [PEAK_WIDTH-1:0]  peak;
    logic [CHAIN_BITS-1:0]  pix;
    logic [31:0]            seed = 32'h6AFFBCEB;
    int                     errorCnt = 0;
    int                     compares = 0;
    note_t                  notes[$];
    note_t                  oldest;

    led_matrix_if linkBus ();

    led_matrix_device led_matrix_device_inst (.clk(clk), .reset_n(reset_n), .link(linkBus.device),
        .ledGroup(ledGroup), .scanPhase(scanPhase), .peakCurrent(peakCurrent),
        .referenceOn(referenceOn), .sleepState(sleepState));

    led_matrix_host led_matrix_host_inst (.clk(clk), .reset_n(reset_n), .link(linkBus.host),
        .sendStart(sendStart), .sendTarget(sendTarget), .sendLen(sendLen), .sendData(sendData),
        .displayOff(displayOff), .oscSelect(oscSelect), .extOsc(extOsc),
        .resetDisplay(resetDisplay), .busy(busy), .done(done));

    led_matrix_sva led_matrix_sva_inst (.clk(clk), .reset_n(reset_n),
        .serClk(linkBus.serClk), .serData(linkBus.serData), .writeWindowN(linkBus.writeWindowN),
        .targetRegisterChoice(linkBus.targetRegisterChoice), .oscSel(linkBus.oscSel),
        .displayOffInput(linkBus.displayOffInput), .oscExt(linkBus.oscExt),
        .deviceResetN(linkBus.deviceResetN), .dataOut(linkBus.dataOut), .oscOut(linkBus.oscOut),
        .oscOutEn(linkBus.oscOutEn), .oscLine(linkBus.oscLine), .ledGroup(ledGroup),
        .scanPhase(scanPhase), .peakCurrent(peakCurrent), .referenceOn(referenceOn),
        .sleepState(sleepState));

    always #5 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
    endfunction

    function automatic logic [39:0] observe(input logic [2:0] sel);
        case (sel)
            3'h0: return ledGroup;
            3'h1: return 40'(scanPhase);
            3'h2: return 40'(peakCurrent);
            3'h3: return 40'(referenceOn);
            3'h4: return 40'(sleepState);
            3'h5: return 40'(linkBus.dataOut);
            3'h6: return 40'(busy);
            default: return 40'(linkBus.oscLine);
        endcase
    endfunction

    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        compares++;
        if (seen !== want) begin
            errorCnt++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic expect_val(input logic [2:0] sel, input logic [39:0] val);
        notes.push_back('{sel, val});
    endtask

    always @(negedge clk) begin
        #1;
        while (notes.size() > 0) begin
            oldest = notes.pop_front();
            check(observe(oldest.sel), oldest.val);
        end
    end

    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic send(input logic t, input logic [LEN_WIDTH-1:0] n,
                        input logic [CHAIN_BITS-1:0] d);
        int w;
        @(negedge clk);
        sendTarget = t;
        sendLen = n;
        sendData = d;
        sendStart = 1'b1;
        @(negedge clk);
        sendStart = 1'b0;
        expect_val(3'h6, 40'h1);
        w = 0;
        while (done !== 1'b1 && w < 10000) begin
            @(negedge clk);
            w++;
        end
        expect_val(3'h6, 40'h0);
        if (done !== 1'b1) begin
            errorCnt++;
        end
    endtask

    task automatic wake(input logic [PEAK_WIDTH-1:0] p);
        send(1'b1, 9'h008, {2'h1, p, 312'h0});
        idle(8);
        expect_val(3'h4, 40'h0);
        expect_val(3'h3, 40'h1);
        expect_val(3'h2, 40'(p));
    endtask

    task automatic scan_check(input int steps);
        int w;
        for (int s = 0; s < steps; s++) begin
            phase = scanPhase;
            w = 0;
            while (scanPhase === phase && w < 2000) begin
                @(negedge clk);
                w++;
            end
            idle(3);
            phase = phase + 3'h1;
            expect_val(3'h1, 40'(phase));
            expect_val(3'h7, 40'h1);
            expect_val(3'h0, pix[phase * SCAN_WIDTH +: SCAN_WIDTH]);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        errorCnt++;
        tally_and_finish();
    end

    initial begin
        idle(10);
        reset_n = 1'b1;
        idle(4);
        expect_val(3'h4, 40'h1);
        expect_val(3'h2, 40'h0);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            pix = {pix[CHAIN_BITS-33:0], seed};
        end
        send(1'b0, 9'h140, pix);
        expect_val(3'h0, 40'h0);
        peak = seed[5:0];
        wake(peak);
        scan_check(8);
        $display("test pixel scan done");
        displayOff = 1'b1;
        idle(8);
        expect_val(3'h0, 40'h0);
        displayOff = 1'b0;
        idle(8);
        expect_val(3'h0, pix[phase * SCAN_WIDTH +: SCAN_WIDTH]);
        $display("test blank done");
        resetDisplay = 1'b1;
        idle(8);
        expect_val(3'h4, 40'h1);
        expect_val(3'h2, 40'h0);
        expect_val(3'h0, 40'h0);
        resetDisplay = 1'b0;
        idle(4);
        seed = lfsr(seed);
        peak = seed[5:0];
        wake(peak);
        scan_check(1);
        $display("test pin reset done");
        oscSelect = 1'b0;
        idle(8);
        phase = scanPhase;
        repeat (4) begin
            extOsc = 1'b1;
            idle(6);
            expect_val(3'h7, 40'h1);
            extOsc = 1'b0;
            idle(7);
        end
        expect_val(3'h1, 40'(phase + 3'h4));
        $display("test external timebase done");
        send(1'b0, 9'h001, '0);
        idle(4);
        expect_val(3'h5, 40'(pix[CHAIN_BITS-1]));
        $display("test cascade out done");
        send(1'b1, 9'h008, {2'h2, 6'h00, 312'h0});
        idle(8);
        expect_val(3'h4, 40'h0);
        expect_val(3'h2, 40'(peak));
        $display("test control word one done");
        idle(2);
        tally_and_finish();
    end
endmodule // testbench
